// >>> mclf_store.sv
// engine-coupled local store: RAM / queue with reused engine pins and programmable pointers
`timescale 1ns/1ps
// Function
// - mode 1 write address expb[7:2], read address {expb[1:0],ce[11:8]}; mode 2 zero
// - modes 1,2 take write strobe ce[7], read strobe ce[6]; mode 0 paired paths
// - output reset held high in mode 0, from rstn[0] in modes 1 and 2
// - pointer reloads from ce[9] and ce[8] only in mode 2, else zero
// - write reload loads write start value on next write-clock edge
// - read reload loads read start value on next read-clock edge
// - seven-bit start and end values per pointer, defaults 00 and 7F
// - full is write = read-1; override overwrites without advance, overflow still flagged
// - empty is read = write; override rereads current word, underflow still flagged
// - without override, full writes dropped, empty reads skipped, both flagged
// - clocks-same 0 gives independent clocks, 1 one shared clock
// - output register off gives asynchronous read, on registers on read clock
// - output reset synchronous for style 0, asynchronous for style 1
// - output reset low clears output register, plus whole memory if clear enabled
// - write and read shapes: 00 72x32, 01 36x64, 10 144x16
// - write control source: paired, engine, engine with reloads, disabled
// - read control source uses same encoding, also selects output reset
// - write data: paired, paired low over engine, accumulators, multiplier B buses
// - accumulator packing 0 two padded 48-bit sums, 1 two padded 24-bit sums
// - almost-full threshold default 3F, almost-empty default 00
// - lookahead shows first word before any read, else only after read
// - each side picks its own clock or the engine clock
// - mode 0 extends paired block RAM address space over dedicated paths
// - overflow on write while full, underflow on read while empty, queue mode
module mclf_store (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // side clock ticks
  input wire logic i_wr_side_tick,
  input wire logic i_rd_side_tick,
  // engine pins reused as store controls
  input wire logic [7:0] i_exp_b,
  input wire logic [11:0] i_ce,
  input wire logic [3:0] i_eng_rst_n,
  // engine data sources
  input wire logic [71:0] i_eng_din,
  input wire logic [47:0] i_low_half_sum,
  input wire logic [47:0] i_high_half_sum,
  input wire logic [71:0] i_multb_hi,
  input wire logic [71:0] i_multb_lo,
  // paired block RAM paths
  input wire logic [143:0] i_paired_write_data,
  input wire logic [5:0] i_paired_wr_addr,
  input wire logic [5:0] i_paired_rd_addr,
  input wire logic i_paired_wr_en,
  input wire logic i_paired_rd_en,
  input wire logic i_paired_sbit_err,
  input wire logic i_paired_dbit_err,
  // store outputs
  output logic [143:0] o_rd_data,
  output logic o_empty,
  output logic o_full,
  output logic o_almost_empty,
  output logic o_almost_full,
  output logic o_write_error,
  output logic o_read_error,
  output logic o_sbit_error,
  output logic o_dbit_error
);

  logic [31:0] ctrl_ff;
  logic [31:0] ptrs_ff;
  logic [31:0] thresh_ff;
  mclf_pkg::mclf_ctrl_t cfg;
  mclf_pkg::mclf_ptrs_t lim;
  mclf_pkg::mclf_thresh_t thr;
  logic [35:0] mem_ff [mclf_pkg::MCLF_SLOTS];
  logic [6:0] wr_ptr_ff;
  logic [6:0] rd_ptr_ff;
  logic [5:0] last_rd_addr_ff;
  logic [143:0] dout_ff;
  logic [143:0] word_at_rd;
  logic [143:0] word_at_last;
  logic [143:0] word_at_next;
  logic [6:0] nxt_rd_ptr;
  logic [143:0] wr_data;
  logic [5:0] wr_addr;
  logic [5:0] rd_addr;
  logic wr_strobe;
  logic rd_strobe;
  logic wr_reload;
  logic rd_reload;
  logic out_rst_n;
  logic wr_tick;
  logic rd_tick;
  logic wr_queue;
  logic rd_queue;
  logic full;
  logic empty;
  logic wr_do;
  logic rd_do;
  logic wr_adv;
  logic rd_adv;
  logic [6:0] occupancy;
  logic [7:0] span;

  assign cfg = mclf_pkg::mclf_ctrl_t'(ctrl_ff);
  assign lim = mclf_pkg::mclf_ptrs_t'(ptrs_ff);
  assign thr = mclf_pkg::mclf_thresh_t'(thresh_ff);

  // next pointer value with programmable wrap
  function automatic logic [6:0] ptr_step(input logic [6:0] p, input logic [6:0] start, input logic [6:0] max);
    ptr_step = (p == max) ? start : 7'(p + 7'h01);
  endfunction

  // first 36-bit slot of a word for a given shape
  function automatic logic [5:0] slot_base(input logic [5:0] addr, input logic [1:0] shape);
    case (shape)
      mclf_pkg::MCLF_SHAPE_36X64: slot_base = addr;
      mclf_pkg::MCLF_SHAPE_144X16: slot_base = {addr[3:0], 2'b00};
      default: slot_base = {addr[4:0], 1'b0};
    endcase
  endfunction

  // gather a read word of the read shape, narrower shapes in the low bits
  function automatic logic [143:0] read_word(input logic [5:0] addr, input logic [1:0] shape,
                                             input logic [2303:0] flat);
    logic [5:0] b;
    b = slot_base(addr, shape);
    case (shape)
      mclf_pkg::MCLF_SHAPE_36X64: read_word = {108'h0, flat[b*36 +: 36]};
      mclf_pkg::MCLF_SHAPE_144X16: read_word = flat[b*36 +: 144];
      default: read_word = {72'h0, flat[b*36 +: 72]};
    endcase
  endfunction

  logic [2303:0] mem_flat;
  genvar g;
  generate
    for (g = 0; g < mclf_pkg::MCLF_SLOTS; g++) begin : g_flat
      assign mem_flat[g*36 +: 36] = mem_ff[g];
    end
  endgenerate

  // control sources per mode
  always_comb begin
    case (cfg.in_mode)
      mclf_pkg::MCLF_MODE_PAIRED: begin
        wr_addr = i_paired_wr_addr;
        wr_strobe = i_paired_wr_en;
        wr_reload = 1'b0;
      end
      mclf_pkg::MCLF_MODE_ENGINE: begin
        wr_addr = i_exp_b[7:2];
        wr_strobe = i_ce[7];
        wr_reload = 1'b0;
      end
      mclf_pkg::MCLF_MODE_RELOAD: begin
        wr_addr = 6'h00;
        wr_strobe = i_ce[7];
        wr_reload = i_ce[9];
      end
      default: begin
        wr_addr = 6'h00;
        wr_strobe = 1'b0;
        wr_reload = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (cfg.out_mode)
      mclf_pkg::MCLF_MODE_PAIRED: begin
        rd_addr = i_paired_rd_addr;
        rd_strobe = i_paired_rd_en;
        rd_reload = 1'b0;
        out_rst_n = 1'b1;
      end
      mclf_pkg::MCLF_MODE_ENGINE: begin
        rd_addr = {i_exp_b[1:0], i_ce[11:8]};
        rd_strobe = i_ce[6];
        rd_reload = 1'b0;
        out_rst_n = i_eng_rst_n[0];
      end
      mclf_pkg::MCLF_MODE_RELOAD: begin
        rd_addr = 6'h00;
        rd_strobe = i_ce[6];
        rd_reload = i_ce[8];
        out_rst_n = i_eng_rst_n[0];
      end
      default: begin
        rd_addr = 6'h00;
        rd_strobe = 1'b0;
        rd_reload = 1'b0;
        out_rst_n = 1'b1;
      end
    endcase
  end

  // write data source
  always_comb begin
    case (cfg.wr_data_mode)
      mclf_pkg::MCLF_WSRC_PAIRED: wr_data = i_paired_write_data;
      mclf_pkg::MCLF_WSRC_MIXED: wr_data = {i_paired_write_data[71:0], i_eng_din};
      mclf_pkg::MCLF_WSRC_ACCUM: begin
        if (cfg.accum_sel) begin
          wr_data = {72'h0, 12'h0, i_low_half_sum[23:0], 12'h0, i_high_half_sum[23:0]};
        end else begin
          wr_data = {24'h0, i_low_half_sum, 24'h0, i_high_half_sum};
        end
      end
      default: wr_data = {i_multb_hi, i_multb_lo};
    endcase
  end

  // each side ticks on its own clock enable or on every engine cycle
  assign wr_tick = cfg.clk_sel_wr | i_wr_side_tick;
  assign rd_tick = cfg.sync_mode ? wr_tick : (cfg.clk_sel_rd | i_rd_side_tick);

  // queue state
  assign wr_queue = cfg.fifo_en
                    && (cfg.in_mode == mclf_pkg::MCLF_MODE_ENGINE || cfg.in_mode == mclf_pkg::MCLF_MODE_RELOAD);
  assign rd_queue = cfg.fifo_en
                    && (cfg.out_mode == mclf_pkg::MCLF_MODE_ENGINE || cfg.out_mode == mclf_pkg::MCLF_MODE_RELOAD);
  assign full = ptr_step(wr_ptr_ff, lim.wr_start, lim.wr_max) == rd_ptr_ff;
  assign empty = rd_ptr_ff == wr_ptr_ff;
  // override keeps the access but freezes the pointer
  assign wr_do = wr_tick && wr_strobe && (!wr_queue || !full || cfg.ignore_flags);
  assign rd_do = rd_tick && rd_strobe && (!rd_queue || !empty || cfg.ignore_flags);
  assign wr_adv = wr_do && wr_queue && !full;
  assign rd_adv = rd_do && rd_queue && !empty;

  assign span = 8'(8'(lim.wr_max) - 8'(lim.wr_start) + 8'h01);
  assign occupancy = (wr_ptr_ff >= rd_ptr_ff) ? 7'(wr_ptr_ff - rd_ptr_ff)
                   : 7'(span - 8'(rd_ptr_ff - wr_ptr_ff));

  // memory: clear has priority, writes split over 36-bit slots by shape
  always_ff @(posedge i_ref_clk) begin
    if (!out_rst_n && cfg.clear_en) begin
      for (int i = 0; i < mclf_pkg::MCLF_SLOTS; i++) begin
        mem_ff[i] <= 36'h0;
      end
    end else if (wr_do) begin
      for (int k = 0; k < 4; k++) begin
        if (k == 0 || (k == 1 && cfg.wr_shape != mclf_pkg::MCLF_SHAPE_36X64)
            || cfg.wr_shape == mclf_pkg::MCLF_SHAPE_144X16) begin
          mem_ff[6'(slot_base(wr_queue ? wr_ptr_ff[5:0] : wr_addr, cfg.wr_shape) + 6'(k))]
            <= wr_data[k*36 +: 36];
        end
      end
    end
  end

  // write pointer
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_ff <= 7'h00;
    end else if (wr_tick && wr_reload && cfg.fifo_en) begin
      wr_ptr_ff <= lim.wr_start;
    end else if (wr_adv) begin
      wr_ptr_ff <= ptr_step(wr_ptr_ff, lim.wr_start, lim.wr_max);
    end
  end

  // read pointer
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_ptr_ff <= 7'h00;
    end else if (rd_tick && rd_reload && cfg.fifo_en) begin
      rd_ptr_ff <= lim.rd_start;
    end else if (rd_adv) begin
      rd_ptr_ff <= ptr_step(rd_ptr_ff, lim.rd_start, lim.rd_max);
    end
  end

  // read data paths
  assign word_at_rd = read_word(rd_queue ? rd_ptr_ff[5:0] : rd_addr, cfg.rd_shape, mem_flat);
  assign word_at_last = read_word(last_rd_addr_ff, cfg.rd_shape, mem_flat);
  assign nxt_rd_ptr = ptr_step(rd_ptr_ff, lim.rd_start, lim.rd_max);
  // a registered lookahead pop must show the following word, not the one just taken
  assign word_at_next = read_word(nxt_rd_ptr[5:0], cfg.rd_shape, mem_flat);

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      last_rd_addr_ff <= 6'h00;
    end else if (rd_do) begin
      last_rd_addr_ff <= rd_queue ? rd_ptr_ff[5:0] : rd_addr;
    end
  end

  // output register; async style clears without waiting for a read tick
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      dout_ff <= 144'h0;
    end else if (!out_rst_n && (cfg.output_reset_style || rd_tick)) begin
      dout_ff <= 144'h0;
    end else if (rd_adv && cfg.fwft) begin
      dout_ff <= word_at_next;
    end else if (rd_do || (rd_tick && rd_queue && cfg.fwft && !empty)) begin
      dout_ff <= word_at_rd;
    end
  end

  // unregistered read stays combinational: a flop here would break the zero-latency read
  always_comb begin
    if (cfg.reg_dout) begin
      o_rd_data = (!out_rst_n && cfg.output_reset_style) ? 144'h0 : dout_ff;
    end else if (rd_queue && !cfg.fwft) begin
      o_rd_data = word_at_last;
    end else begin
      o_rd_data = word_at_rd;
    end
  end

  // flags, one cycle behind the pointers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_empty <= 1'b1;
      o_full <= 1'b0;
      o_almost_empty <= 1'b1;
      o_almost_full <= 1'b0;
      o_write_error <= 1'b0;
      o_read_error <= 1'b0;
      o_sbit_error <= 1'b0;
      o_dbit_error <= 1'b0;
    end else begin
      o_empty <= empty;
      o_full <= full;
      o_almost_empty <= occupancy <= thr.aempty;
      o_almost_full <= occupancy >= thr.afull;
      o_write_error <= wr_queue && wr_tick && wr_strobe && full;
      o_read_error <= rd_queue && rd_tick && rd_strobe && empty;
      o_sbit_error <= i_paired_sbit_err;
      o_dbit_error <= i_paired_dbit_err;
    end
  end

  // configuration registers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= mclf_pkg::MCLF_CTRL_RST;
      ptrs_ff <= mclf_pkg::MCLF_PTRS_RST;
      thresh_ff <= mclf_pkg::MCLF_THRESH_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        mclf_pkg::MCLF_OFS_CTRL: ctrl_ff <= {12'h000, i_reg_wdata[19:0]};
        mclf_pkg::MCLF_OFS_PTRS: ptrs_ff <= i_reg_wdata & 32'h7F7F7F7F;
        mclf_pkg::MCLF_OFS_THRESH: thresh_ff <= i_reg_wdata & 32'h00007F7F;
        default: ;
      endcase
    end
  end

  // register read data, valid the cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata <= 32'h0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        mclf_pkg::MCLF_OFS_CTRL: o_reg_rdata <= ctrl_ff;
        mclf_pkg::MCLF_OFS_PTRS: o_reg_rdata <= ptrs_ff;
        mclf_pkg::MCLF_OFS_THRESH: o_reg_rdata <= thresh_ff;
        mclf_pkg::MCLF_OFS_STATUS: o_reg_rdata <= {12'h000, o_almost_full, o_almost_empty, o_full, o_empty,
                                                    1'b0, rd_ptr_ff, 1'b0, wr_ptr_ff};
        default: o_reg_rdata <= 32'h0;
      endcase
    end
  end

endmodule

// >>> mclf_pkg.sv
// package: register map, configuration layout and codes for the engine-coupled local store
package mclf_pkg;

  // register port
  localparam int MCLF_ADDR_W = 4;
  localparam logic [3:0] MCLF_OFS_CTRL = 4'h0;
  localparam logic [3:0] MCLF_OFS_PTRS = 4'h4;
  localparam logic [3:0] MCLF_OFS_THRESH = 4'h8;
  localparam logic [3:0] MCLF_OFS_STATUS = 4'hC;

  // storage geometry: 64 slots of 36 bits, 2304 bits in total
  localparam int MCLF_SLOT_W = 36;
  localparam int MCLF_SLOTS = 64;
  localparam int MCLF_DATA_W = 144;
  localparam int MCLF_PTR_W = 7;

  // control-source modes, shared by write side and read side
  typedef enum logic [1:0] {
    MCLF_MODE_PAIRED = 2'b00,
    MCLF_MODE_ENGINE = 2'b01,
    MCLF_MODE_RELOAD = 2'b10,
    MCLF_MODE_OFF    = 2'b11
  } mclf_mode_t;

  // width/depth shapes
  localparam logic [1:0] MCLF_SHAPE_72X32 = 2'b00;
  localparam logic [1:0] MCLF_SHAPE_36X64 = 2'b01;
  localparam logic [1:0] MCLF_SHAPE_144X16 = 2'b10;

  // write-data sources
  localparam logic [1:0] MCLF_WSRC_PAIRED = 2'b00;
  localparam logic [1:0] MCLF_WSRC_MIXED = 2'b01;
  localparam logic [1:0] MCLF_WSRC_ACCUM = 2'b10;
  localparam logic [1:0] MCLF_WSRC_MULTB = 2'b11;

  // control register layout, bit 0 at in_mode
  typedef struct packed {
    logic [11:0] spare;
    logic clk_sel_rd;
    logic clk_sel_wr;
    logic clear_en;
    logic output_reset_style;
    logic reg_dout;
    logic sync_mode;
    logic fwft;
    logic ignore_flags;
    logic fifo_en;
    logic accum_sel;
    logic [1:0] wr_data_mode;
    logic [1:0] rd_shape;
    logic [1:0] wr_shape;
    mclf_mode_t out_mode;
    mclf_mode_t in_mode;
  } mclf_ctrl_t;

  // pointer limits register layout
  typedef struct packed {
    logic pad3;
    logic [6:0] rd_max;
    logic pad2;
    logic [6:0] rd_start;
    logic pad1;
    logic [6:0] wr_max;
    logic pad0;
    logic [6:0] wr_start;
  } mclf_ptrs_t;

  // threshold register layout
  typedef struct packed {
    logic [16:0] spare;
    logic [6:0] aempty;
    logic pad;
    logic [6:0] afull;
  } mclf_thresh_t;

  // reset values
  localparam logic [31:0] MCLF_CTRL_RST = 32'h00000000;
  localparam logic [31:0] MCLF_PTRS_RST = 32'h7F007F00;
  localparam logic [31:0] MCLF_THRESH_RST = 32'h0000003F;

endpackage

// >>> mclf_store_sva.sv
// assertion checker for the engine-coupled local store ports
`timescale 1ns/1ps
module mclf_store_sva (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // watched ports
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic [11:0] i_ce,
  input wire logic i_paired_wr_en,
  input wire logic i_paired_rd_en,
  input wire logic i_paired_sbit_err,
  input wire logic i_paired_dbit_err,
  input wire logic o_empty,
  input wire logic o_full,
  input wire logic o_almost_empty,
  input wire logic o_write_error,
  input wire logic o_read_error,
  input wire logic o_sbit_error,
  input wire logic o_dbit_error
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_odd_rd;
    i_reg_rd ##0 (i_reg_addr[1:0] != 2'h0);
  endsequence
  sequence s_no_rd;
    !i_reg_rd ##1 1'b1;
  endsequence
  property p_unmapped;
    s_odd_rd |=> o_reg_rdata == 32'h0;
  endproperty
  property p_hold;
    s_no_rd |-> $stable(o_reg_rdata);
  endproperty
  property p_sbit;
    1'b1 |=> o_sbit_error == $past(i_paired_sbit_err);
  endproperty
  property p_dbit;
    1'b1 |=> o_dbit_error == $past(i_paired_dbit_err);
  endproperty
  property p_werr;
    o_write_error |-> $past(i_ce[7] | i_paired_wr_en);
  endproperty
  property p_rerr;
    o_read_error |-> $past(i_ce[6] | i_paired_rd_en);
  endproperty
  property p_excl;
    !(o_full && o_empty);
  endproperty
  property p_ae;
    o_empty |-> o_almost_empty;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_sbit: assert property (p_sbit) else $error("single-bit flag not passed");
  a_dbit: assert property (p_dbit) else $error("double-bit flag not passed");
  a_werr: assert property (p_werr) else $error("write error without strobe");
  a_rerr: assert property (p_rerr) else $error("read error without strobe");
  a_excl: assert property (p_excl) else $error("full and empty together");
  a_ae: assert property (p_ae) else $error("empty but not almost empty");
endmodule
bind mclf_store mclf_store_sva u_sva (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_ce(i_ce),
  .i_paired_wr_en(i_paired_wr_en), .i_paired_rd_en(i_paired_rd_en),
  .i_paired_sbit_err(i_paired_sbit_err), .i_paired_dbit_err(i_paired_dbit_err),
  .o_empty(o_empty), .o_full(o_full), .o_almost_empty(o_almost_empty),
  .o_write_error(o_write_error), .o_read_error(o_read_error),
  .o_sbit_error(o_sbit_error), .o_dbit_error(o_dbit_error));

// >>> mclf_paired_model.sv
// paired block RAM side: drives the dedicated paths one cycle per bench command
`timescale 1ns/1ps
module mclf_paired_model (
  // clock
  input wire logic i_ref_clk,
  // bench commands
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [5:0] i_addr,
  input wire logic [143:0] i_data,
  input wire logic [1:0] i_err,
  // dedicated paths
  output logic [143:0] o_wr_data,
  output logic [5:0] o_wr_addr,
  output logic [5:0] o_rd_addr,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic o_sbit,
  output logic o_dbit
);
  // idle paths show the inverse of the command so a stray sample of them shows up
  always @(posedge i_ref_clk) begin
    o_wr_en <= i_wr;
    o_rd_en <= i_rd;
    o_wr_addr <= i_wr ? i_addr : ~i_addr;
    o_rd_addr <= i_rd ? i_addr : ~i_addr;
    o_wr_data <= i_wr ? i_data : ~i_data;
    {o_sbit, o_dbit} <= i_err;
  end
endmodule

// >>> mclf_store_tb_top.sv
// self-checking bench for the engine-coupled local store
`timescale 1ns/1ps
module mclf_store_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] ce = 12'h000;
  logic [3:0] rn = 4'hF;
  logic [71:0] din = {9{8'hA5}};
  logic [47:0] lo = 48'h123456789ABC;
  logic [47:0] hi = 48'hFEDCBA987654;
  logic [71:0] mbh = {9{8'h5A}};
  logic [71:0] mbl = {9{8'h3C}};
  logic pw = 1'b0;
  logic pr = 1'b0;
  logic [5:0] pa = 6'h0;
  logic [143:0] pd = {9{16'h1E2D}};
  logic [1:0] err = 2'b00;
  logic [7:0] eb = 8'h00;
  logic st = 1'b0;
  logic afl;
  logic [143:0] p_wd;
  logic [5:0] p_wa;
  logic [5:0] p_ra;
  logic p_we;
  logic p_re;
  logic p_sb;
  logic p_db;
  logic [31:0] rdat;
  logic [143:0] rdd;
  logic emp;
  logic ful;
  logic werr;
  logic rerr;
  int n_fail = 0;
  int n_checks = 0;
  mclf_pkg::mclf_ctrl_t cf;

  initial begin
    forever #2.5 clk = ~clk;
  end

  mclf_paired_model u_pair (.i_ref_clk(clk), .i_wr(pw), .i_rd(pr), .i_addr(pa), .i_data(pd),
    .i_err(err), .o_wr_data(p_wd), .o_wr_addr(p_wa), .o_rd_addr(p_ra), .o_wr_en(p_we),
    .o_rd_en(p_re), .o_sbit(p_sb), .o_dbit(p_db));

  mclf_store DUT (.i_ref_clk(clk), .i_reset(rst), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_wr_side_tick(st),
    .i_rd_side_tick(st), .i_exp_b(eb), .i_ce(ce), .i_eng_rst_n(rn), .i_eng_din(din),
    .i_low_half_sum(lo), .i_high_half_sum(hi), .i_multb_hi(mbh), .i_multb_lo(mbl),
    .i_paired_write_data(p_wd), .i_paired_wr_addr(p_wa), .i_paired_rd_addr(p_ra),
    .i_paired_wr_en(p_we), .i_paired_rd_en(p_re), .i_paired_sbit_err(p_sb),
    .i_paired_dbit_err(p_db), .o_rd_data(rdd), .o_empty(emp), .o_full(ful),
    .o_almost_empty(), .o_almost_full(afl), .o_write_error(werr), .o_read_error(rerr),
    .o_sbit_error(), .o_dbit_error());

  task automatic final_report;
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [143:0] g, input logic [143:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rgw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data appear in the cycle after the strobe and hold until the next read, so sample right there
  task automatic rgr(input logic [3:0] a);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask

  task automatic eng(input logic [11:0] v, input logic [143:0] d);
    @(posedge clk);
    {mbh, mbl} <= d;
    ce <= v;
    @(posedge clk);
    ce <= 12'h000;
    #1;
  endtask

  // model registers the command, store takes it one edge later
  task automatic pcmd(input logic w, input logic r, input logic [5:0] a);
    @(posedge clk);
    pw <= w;
    pr <= r;
    pa <= a;
    @(posedge clk);
    pw <= 1'b0;
    pr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rstp;
    @(posedge clk);
    rn <= 4'hE;
    @(posedge clk);
    rn <= 4'hF;
    #1;
  endtask

  function automatic logic [143:0] src(input int k);
    case (k)
      0: return pd;
      1: return {pd[71:0], din};
      2: return {24'h000000, lo, 24'h000000, hi};
      3: return {84'h0, lo[23:0], 12'h000, hi[23:0]};
      default: return {mbh, mbl};
    endcase
  endfunction

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rgr(4'h0);
    chk(rdat, 32'h0);
    rgr(4'h4);
    chk(rdat, mclf_pkg::MCLF_PTRS_RST);
    rgr(4'h8);
    chk(rdat, mclf_pkg::MCLF_THRESH_RST);
    rgr(4'h2);
    chk(rdat, 32'h0);
    rgr(4'hC);
    chk(rdat[19:16], 4'h5);
    $display("test reset done");
    cf = '0;
    cf.in_mode = mclf_pkg::MCLF_MODE_ENGINE;
    cf.out_mode = mclf_pkg::MCLF_MODE_ENGINE;
    cf.wr_shape = mclf_pkg::MCLF_SHAPE_144X16;
    cf.rd_shape = mclf_pkg::MCLF_SHAPE_144X16;
    cf.wr_data_mode = mclf_pkg::MCLF_WSRC_MULTB;
    cf.fifo_en = 1'b1;
    cf.reg_dout = 1'b1;
    cf.clk_sel_wr = 1'b1;
    cf.clk_sel_rd = 1'b1;
    rgw(4'h0, cf);
    rgw(4'h4, 32'h03000300);
    rgw(4'h8, 32'h00000003);
    for (int i = 1; i <= 3; i++) eng(12'h080, {18{8'(i)}});
    eng(12'h080, {18{8'h09}});
    chk(werr, 1'b1);
    chk(ful, 1'b1);
    chk(afl, 1'b1);
    for (int i = 1; i <= 3; i++) begin
      eng(12'h040, {mbh, mbl});
      chk(rdd, {18{8'(i)}});
    end
    eng(12'h040, {mbh, mbl});
    chk(rerr, 1'b1);
    $display("test queue done");
    cf.ignore_flags = 1'b1;
    rgw(4'h0, cf);
    for (int i = 4; i <= 6; i++) eng(12'h080, {18{8'(i)}});
    eng(12'h080, {18{8'h07}});
    chk(werr, 1'b1);
    for (int i = 4; i <= 6; i++) begin
      eng(12'h040, {mbh, mbl});
      chk(rdd, {18{8'(i)}});
    end
    for (int i = 0; i < 2; i++) begin
      eng(12'h040, {mbh, mbl});
      chk(rdd, {18{8'h07}});
      chk(rerr, 1'b1);
    end
    $display("test override done");
    cf.in_mode = mclf_pkg::MCLF_MODE_RELOAD;
    cf.out_mode = mclf_pkg::MCLF_MODE_RELOAD;
    rgw(4'h0, cf);
    rgw(4'h4, 32'h03010301);
    eng(12'h300, {mbh, mbl});
    rgr(4'hC);
    chk(rdat[14:0], 15'h0101);
    cf.in_mode = mclf_pkg::MCLF_MODE_ENGINE;
    cf.out_mode = mclf_pkg::MCLF_MODE_ENGINE;
    rgw(4'h0, cf);
    eng(12'h080, {18{8'h0B}});
    eng(12'h200, {mbh, mbl});
    rgr(4'hC);
    chk(rdat[6:0], 7'h02);
    cf.fwft = 1'b1;
    rgw(4'h0, cf);
    @(posedge clk);
    #1;
    chk(rdd, {18{8'h0B}});
    $display("test reload done");
    cf = '0;
    cf.wr_shape = mclf_pkg::MCLF_SHAPE_144X16;
    cf.rd_shape = mclf_pkg::MCLF_SHAPE_144X16;
    cf.reg_dout = 1'b1;
    cf.clk_sel_wr = 1'b1;
    cf.clk_sel_rd = 1'b1;
    err <= 2'b10;
    for (int k = 0; k < 5; k++) begin
      cf.wr_data_mode = (k == 4) ? 2'b11 : ((k == 3) ? 2'b10 : 2'(k));
      cf.accum_sel = (k == 3);
      rgw(4'h0, cf);
      pcmd(1'b1, 1'b0, 6'(k + 1));
      pcmd(1'b0, 1'b1, 6'(k + 1));
      chk(rdd, src(k));
    end
    err <= 2'b01;
    $display("test sources done");
    cf.clear_en = 1'b1;
    cf.output_reset_style = 1'b1;
    rgw(4'h0, cf);
    rstp();
    chk(rdd, src(4));
    cf.in_mode = mclf_pkg::MCLF_MODE_ENGINE;
    cf.out_mode = mclf_pkg::MCLF_MODE_ENGINE;
    rgw(4'h0, cf);
    rstp();
    chk(rdd, 144'h0);
    cf.in_mode = mclf_pkg::MCLF_MODE_PAIRED;
    cf.out_mode = mclf_pkg::MCLF_MODE_PAIRED;
    rgw(4'h0, cf);
    pcmd(1'b0, 1'b1, 6'h01);
    chk(rdd, 144'h0);
    $display("test output reset done");
    cf = '0;
    cf.in_mode = mclf_pkg::MCLF_MODE_ENGINE;
    cf.out_mode = mclf_pkg::MCLF_MODE_ENGINE;
    cf.wr_shape = mclf_pkg::MCLF_SHAPE_36X64;
    cf.rd_shape = mclf_pkg::MCLF_SHAPE_36X64;
    cf.wr_data_mode = mclf_pkg::MCLF_WSRC_MULTB;
    cf.clk_sel_rd = 1'b1;
    rgw(4'h0, cf);
    eb <= 8'h82;
    eng(12'h080, {18{8'hC3}});
    chk(rdd, 144'h0);
    @(posedge clk);
    st <= 1'b1;
    eng(12'h080, {18{8'hC3}});
    chk(rdd, {108'h0, 36'h3C3C3C3C3});
    $display("test pins done");
    final_report();
  end
endmodule
